// ---- usrc_pkg.sv ----
// shared constants and carrier types for the usb supply regulator control
package usrc_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int NUM_EV = 3;

    // register offsets
    localparam logic [11:0] OFF_EV_ARRIVAL  = 12'h100;
    localparam logic [11:0] OFF_EV_LOSS     = 12'h104;
    localparam logic [11:0] OFF_EV_READY    = 12'h108;
    localparam logic [11:0] OFF_PUB_ARRIVAL = 12'h180;
    localparam logic [11:0] OFF_PUB_LOSS    = 12'h184;
    localparam logic [11:0] OFF_PUB_READY   = 12'h188;
    localparam logic [11:0] OFF_IRQ_EN      = 12'h300;
    localparam logic [11:0] OFF_IRQ_EN_SET  = 12'h304;
    localparam logic [11:0] OFF_IRQ_EN_CLR  = 12'h308;
    localparam logic [11:0] OFF_SUPPLY_STAT = 12'h400;
    localparam logic [11:0] OFF_RESET_CAUSE = 12'h500;

    // event indices, also bit positions in the irq enable registers
    localparam int EV_ARRIVAL = 0;
    localparam int EV_LOSS    = 1;
    localparam int EV_READY   = 2;

    // field positions
    localparam int EV_FLAG_BIT    = 0;
    localparam int STAT_VBUS_BIT  = 0;
    localparam int STAT_READY_BIT = 1;
    localparam int CAUSE_VBUS_BIT = 0;
    localparam int PUB_CHAN_W     = 8;
    localparam int PUB_EN_BIT     = 31;

    // reset values
    localparam logic [31:0] EV_RESET     = 32'h0000_0000;
    localparam logic [31:0] PUB_RESET    = 32'h0000_0000;
    localparam logic [2:0]  IRQ_EN_RESET = 3'h0;

    // timing: worst case regulator settling time and clock rate
    localparam int SETTLE_TIME_US = 1600;
    localparam int CLK_KHZ        = 10000;
    localparam int SETTLE_CYCLES  = (SETTLE_TIME_US * CLK_KHZ + 999) / 1000;

    // register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } usrc_bus_req_t;

    // one event published onto the event interconnect
    typedef struct packed {
        logic                  fire;
        logic [PUB_CHAN_W-1:0] chan;
    } usrc_pub_t;

    // chip power state as seen by this block
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_WAKE
    } usrc_pwr_t;

endpackage

// ---- usrc_settle_timer.sv ----
// regulator settling timer: ready level and ready pulse after enable
`timescale 1ns/1ps
`default_nettype none
module usrc_settle_timer
    import usrc_pkg::*;
#(
    parameter int CYCLES = SETTLE_CYCLES
) (
    // clock and reset
    input  wire logic mclk_in,
    input  wire logic reset_n_in,
    // control
    input  wire logic enable_in,
    // result
    output logic      ready_out,
    output logic      ready_pulse_out
);

    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    logic [CNT_W-1:0] count_reg;
    logic             ready_reg;

    // counts while enabled until ready, restarts whenever the regulator drops
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_reg <= '0;
        end else if (!enable_in) begin
            count_reg <= '0;
        end else if (!ready_reg) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // ready stands until the regulator is switched off
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ready_reg <= 1'b0;
        end else if (!enable_in) begin
            ready_reg <= 1'b0;
        end else if (count_reg == LAST) begin
            ready_reg <= 1'b1;
        end
    end

    assign ready_out       = ready_reg;
    assign ready_pulse_out = enable_in && !ready_reg && (count_reg == LAST);

endmodule
`default_nettype wire

// ---- usrc_core.sv ----
// usb supply regulator control: vbus events, regulator switch, registers
//
// Summary of operation
// - a vbus rise into range sets the arrival event flag at offset 0x100.
// - a vbus fall out of range sets the loss event flag at offset 0x104.
// - in deep sleep a vbus rise requests a chip reset, then running state.
// - a vbus wakeup from deep sleep sets the vbus bit of the reset cause.
// - the regulator is on only while usb enable and vbus are both present.
// - the ready event at 0x108 is set once settling time has elapsed.
// - supply state at 0x400 shows vbus detection and regulator readiness.
// - each event register holds one flag in bit 0, reset to zero.
// - three publish registers at 0x180..0x188 route the events outward.
// - irq enable, enable set and enable clear sit at 0x300..0x308.
// - writing 1 to set or clear enables or disables; reads show enables.
// - supply state bit 0 is vbus detection and the events follow it.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module usrc_core
    import usrc_pkg::*;
#(
    parameter int SETTLE_CNT = SETTLE_CYCLES
) (
    // clock and reset
    input  wire logic                  mclk_in,
    input  wire logic                  reset_n_in,
    // register bus
    input  wire usrc_bus_req_t         bus_in,
    output logic [DATA_W-1:0]          rdata_out,
    // vbus comparator pin and usb controller enable
    input  wire logic                  vbus_detect_in,
    input  wire logic                  usb_device_controller_enable_in,
    // power management
    input  wire logic                  sleep_req_in,
    output logic                       chip_reset_req_out,
    output logic                       running_out,
    // regulator and events
    output logic                       reg_on_out,
    output usrc_pub_t [NUM_EV-1:0]     pub_out,
    output logic                       irq_out
);

    logic              vbus_meta_reg;
    logic              vbus_present_flag;
    logic              vbus_prev_reg;
    logic              arrival;
    logic              loss;
    logic              reg_on;
    logic              ready;
    logic              ready_pulse;
    logic [NUM_EV-1:0] ev_reg;
    logic [NUM_EV-1:0] ev_hit;
    logic [NUM_EV-1:0] irq_en_reg;
    logic [DATA_W-1:0] pub_cfg_reg [NUM_EV];
    logic              cause_vbus_reg;
    usrc_pwr_t         pwr_reg;
    usrc_pwr_t         pwr_next;
    logic              wr_hit;
    logic [DATA_W-1:0] rdata_reg;
    usrc_pub_t [NUM_EV-1:0] pub_reg;

    // true when a write strobe addresses the given offset
    function automatic logic wr_at(input usrc_bus_req_t req,
                                   input logic [11:0] off);
        return req.wr && (req.addr == off);
    endfunction

    // vbus pin passes two flops before anything reads it
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            vbus_meta_reg     <= 1'b0;
            vbus_present_flag <= 1'b0;
        end else begin
            vbus_meta_reg     <= vbus_detect_in;
            vbus_present_flag <= vbus_meta_reg;
        end
    end

    // previous detection state for edge finding
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            vbus_prev_reg <= 1'b0;
        end else begin
            vbus_prev_reg <= vbus_present_flag;
        end
    end

    // events derive from changes of the detection bit
    assign arrival = vbus_present_flag && !vbus_prev_reg;
    assign loss    = !vbus_present_flag && vbus_prev_reg;

    // regulator switch
    assign reg_on     = usb_device_controller_enable_in && vbus_present_flag;
    assign reg_on_out = reg_on;

    // settling timer behind the regulator switch
    usrc_settle_timer #(
        .CYCLES          (SETTLE_CNT)
    ) u_settle (
        .mclk_in         (mclk_in),
        .reset_n_in      (reset_n_in),
        .enable_in       (reg_on),
        .ready_out       (ready),
        .ready_pulse_out (ready_pulse)
    );

    // hardware event sources in event order
    assign ev_hit = {ready_pulse, loss, arrival};

    // sticky event flags; a hardware set wins over a software clear
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ev_reg <= EV_RESET[NUM_EV-1:0];
        end else begin
            if (wr_at(bus_in, OFF_EV_ARRIVAL)) begin
                ev_reg[EV_ARRIVAL] <= bus_in.wdata[EV_FLAG_BIT];
            end
            if (wr_at(bus_in, OFF_EV_LOSS)) begin
                ev_reg[EV_LOSS] <= bus_in.wdata[EV_FLAG_BIT];
            end
            if (wr_at(bus_in, OFF_EV_READY)) begin
                ev_reg[EV_READY] <= bus_in.wdata[EV_FLAG_BIT];
            end
            if (arrival) begin
                ev_reg[EV_ARRIVAL] <= 1'b1;
            end
            if (loss) begin
                ev_reg[EV_LOSS] <= 1'b1;
            end
            if (ready_pulse) begin
                ev_reg[EV_READY] <= 1'b1;
            end
        end
    end

    // interrupt enables: plain write, write-one-to-set, write-one-to-clear
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_en_reg <= IRQ_EN_RESET;
        end else if (wr_at(bus_in, OFF_IRQ_EN)) begin
            irq_en_reg <= bus_in.wdata[NUM_EV-1:0];
        end else if (wr_at(bus_in, OFF_IRQ_EN_SET)) begin
            irq_en_reg <= irq_en_reg | bus_in.wdata[NUM_EV-1:0];
        end else if (wr_at(bus_in, OFF_IRQ_EN_CLR)) begin
            irq_en_reg <= irq_en_reg & ~bus_in.wdata[NUM_EV-1:0];
        end
    end

    // level interrupt while any enabled flag is set
    assign irq_out = |(ev_reg & irq_en_reg);

    // publish configuration, one word per event
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pub_cfg_reg[EV_ARRIVAL] <= PUB_RESET;
            pub_cfg_reg[EV_LOSS]    <= PUB_RESET;
            pub_cfg_reg[EV_READY]   <= PUB_RESET;
        end else begin
            if (wr_at(bus_in, OFF_PUB_ARRIVAL)) begin
                pub_cfg_reg[EV_ARRIVAL] <= bus_in.wdata;
            end
            if (wr_at(bus_in, OFF_PUB_LOSS)) begin
                pub_cfg_reg[EV_LOSS] <= bus_in.wdata;
            end
            if (wr_at(bus_in, OFF_PUB_READY)) begin
                pub_cfg_reg[EV_READY] <= bus_in.wdata;
            end
        end
    end

    // one-cycle publish pulse on the configured channel
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pub_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_EV; i++) begin
                pub_reg[i].fire <= ev_hit[i]
                                   && pub_cfg_reg[i][PUB_EN_BIT];
                pub_reg[i].chan <= pub_cfg_reg[i][PUB_CHAN_W-1:0];
            end
        end
    end

    assign pub_out = pub_reg;

    // power state: deep sleep, wake reset request, running
    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            PWR_RUN: begin
                if (sleep_req_in) begin
                    pwr_next = PWR_SLEEP;
                end
            end
            PWR_SLEEP: begin
                if (arrival) begin
                    pwr_next = PWR_WAKE;
                end
            end
            PWR_WAKE: begin
                pwr_next = PWR_RUN;
            end
            default: begin
                pwr_next = PWR_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pwr_reg <= PWR_RUN;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    assign chip_reset_req_out = (pwr_reg == PWR_WAKE);
    assign running_out        = (pwr_reg == PWR_RUN);

    // reset cause vbus bit, write one to clear, wakeup wins
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cause_vbus_reg <= 1'b0;
        end else if (pwr_reg == PWR_SLEEP && arrival) begin
            cause_vbus_reg <= 1'b1;
        end else if (wr_at(bus_in, OFF_RESET_CAUSE)
                     && bus_in.wdata[CAUSE_VBUS_BIT]) begin
            cause_vbus_reg <= 1'b0;
        end
    end

    // read mux, data stand one cycle after the strobe, unmapped reads zero
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_reg <= '0;
        end else if (bus_in.rd) begin
            rdata_reg <= '0;
            case (bus_in.addr)
                OFF_EV_ARRIVAL:  rdata_reg[EV_FLAG_BIT] <= ev_reg[EV_ARRIVAL];
                OFF_EV_LOSS:     rdata_reg[EV_FLAG_BIT] <= ev_reg[EV_LOSS];
                OFF_EV_READY:    rdata_reg[EV_FLAG_BIT] <= ev_reg[EV_READY];
                OFF_PUB_ARRIVAL: rdata_reg <= pub_cfg_reg[EV_ARRIVAL];
                OFF_PUB_LOSS:    rdata_reg <= pub_cfg_reg[EV_LOSS];
                OFF_PUB_READY:   rdata_reg <= pub_cfg_reg[EV_READY];
                OFF_IRQ_EN,
                OFF_IRQ_EN_SET,
                OFF_IRQ_EN_CLR: begin
                    rdata_reg[NUM_EV-1:0] <= irq_en_reg;
                end
                OFF_SUPPLY_STAT: begin
                    rdata_reg[STAT_VBUS_BIT]  <= vbus_present_flag;
                    rdata_reg[STAT_READY_BIT] <= ready;
                end
                OFF_RESET_CAUSE: begin
                    rdata_reg[CAUSE_VBUS_BIT] <= cause_vbus_reg;
                end
                default: begin
                    rdata_reg <= '0;
                end
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign rdata_out = rdata_reg;

    // any write this cycle, used by the checks below
    assign wr_hit = bus_in.wr;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);

    chk_arrival_flag: assert property (
        arrival |=> ev_reg[EV_ARRIVAL])
        else $error("arrival did not set its flag");

    chk_loss_flag: assert property (
        $fell(vbus_present_flag) |=> ev_reg[EV_LOSS])
        else $error("loss did not set its flag");

    chk_wake_reset: assert property (
        (pwr_reg == PWR_SLEEP && $rose(vbus_present_flag))
        |=> chip_reset_req_out ##1 (running_out && !chip_reset_req_out))
        else $error("vbus wakeup did not reset then run");

    chk_cause_set: assert property (
        chip_reset_req_out |-> cause_vbus_reg)
        else $error("wakeup without vbus reset cause");

    chk_reg_switch: assert property (
        reg_on_out == (usb_device_controller_enable_in && vbus_present_flag))
        else $error("regulator switch does not follow enable and vbus");

    chk_ready_event: assert property (
        $rose(ready) |-> $past(reg_on_out) ##0 ev_reg[EV_READY] [*1] ##0
        !$past(ready))
        else $error("ready without a ready event");

    chk_status_read: assert property (
        (bus_in.rd && bus_in.addr == OFF_SUPPLY_STAT)
        |=> rdata_out[1:0] == {$past(ready), $past(vbus_present_flag)}
            && rdata_out[DATA_W-1:2] == '0)
        else $error("supply state read is wrong");

    chk_enable_set: assert property (
        (wr_at(bus_in, OFF_IRQ_EN_SET) && bus_in.wdata[EV_READY])
        |=> irq_en_reg[EV_READY] ##1 (irq_en_reg[EV_READY] || wr_hit
            || $past(wr_hit)))
        else $error("enable set did not enable");

    chk_irq_level: assert property (
        (ev_reg[EV_LOSS] && irq_en_reg[EV_LOSS]) |-> irq_out)
        else $error("enabled flag without interrupt");

    chk_publish_pulse: assert property (
        (loss && pub_cfg_reg[EV_LOSS][PUB_EN_BIT])
        |=> pub_out[EV_LOSS].fire ##1 !pub_out[EV_LOSS].fire)
        else $error("loss was not published for one cycle");

    cov_arrival_irq: cover property (arrival ##1 irq_out);
    cov_wake: cover property (pwr_reg == PWR_SLEEP ##[1:50] running_out);
    cov_ready: cover property (reg_on_out ##1 ready_pulse);

endmodule
`default_nettype wire

// ---- usrc_vbus_model.sv ----
// behavioural model of the vbus supply and the usb controller enable
`timescale 1ns/1ps
`default_nettype none
module usrc_vbus_model #(
    parameter int DELAY_NS = 37
) (
    // commands from the bench
    input  wire logic plug_in,
    input  wire logic usb_on_in,
    // pins toward the block
    output var logic  vbus_out,
    output var logic  usb_device_controller_en_out
);
    // cable level lands off the clock grid, as a real comparator would
    initial vbus_out = 1'b0;
    always @(plug_in) vbus_out <= #(DELAY_NS) plug_in;
    // controller enable is a plain level in the block's clock domain
    always_comb usb_device_controller_en_out = usb_on_in;
endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the usb supply regulator control
`timescale 1ns/1ps
`default_nettype none
module testbench
    import usrc_pkg::*;
;
    localparam int SETTLE = 8;
    logic                   mclk_in;
    logic                   reset_n_in;
    usrc_bus_req_t          bus_in;
    logic [DATA_W-1:0]      rdata_out;
    logic                   vbus_detect_in;
    logic                   usb_device_controller_enable_in;
    logic                   sleep_req_in;
    logic                   chip_reset_req_out;
    logic                   running_out;
    logic                   reg_on_out;
    usrc_pub_t [NUM_EV-1:0] pub_out;
    logic                   irq_out;
    logic                   plug;
    logic                   usb_on;
    int                     fails;
    int                     compares;
    int                     n;

    usrc_core #(.SETTLE_CNT(SETTLE)) i_usrc_core (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .bus_in(bus_in),
        .rdata_out(rdata_out), .vbus_detect_in(vbus_detect_in),
        .usb_device_controller_enable_in(usb_device_controller_enable_in), .sleep_req_in(sleep_req_in),
        .chip_reset_req_out(chip_reset_req_out), .running_out(running_out),
        .reg_on_out(reg_on_out), .pub_out(pub_out), .irq_out(irq_out));

    usrc_vbus_model i_usrc_vbus_model (
        .plug_in(plug), .usb_on_in(usb_on), .vbus_out(vbus_detect_in),
        .usb_device_controller_en_out(usb_device_controller_enable_in));

    // clock at 10 MHz
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end

    // compare one value and count it
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle register write
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_in);
        bus_in.wr <= 1'b0;
        #1;
    endtask

    // one-cycle register read, data taken in the following cycle
    task automatic rd_chk(input string what, input logic [11:0] a,
                          input logic [31:0] exp);
        @(posedge mclk_in);
        bus_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_in);
        bus_in.rd <= 1'b0;
        #1;
        chk(what, exp, rdata_out);
    endtask

    // select an output to wait on
    function automatic logic pick(input int k);
        case (k)
            0, 1, 2: return pub_out[k].fire;
            3:       return chip_reset_req_out;
            4:       return reg_on_out;
            default: return running_out;
        endcase
    endfunction

    // bounded wait for an output, cycles counted in n
    task automatic wait_on(input int k, input string what);
        n = 0;
        while (pick(k) !== 1'b1 && n < 40) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        chk(what, 32'h1, {31'h0, pick(k)});
    endtask

    // verdict and end of run
    task automatic conclude();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        fails = 0;
        compares = 0;
        bus_in = '0;
        plug = 1'b0;
        usb_on = 1'b0;
        sleep_req_in = 1'b0;
        reset_n_in = 1'b0;
        repeat (8) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        // reset values of the event, publish, irq enable and status registers
        for (int i = 0; i < 3; i++) begin
            rd_chk("event", OFF_EV_ARRIVAL + 12'(4 * i), EV_RESET);
            rd_chk("pub", OFF_PUB_ARRIVAL + 12'(4 * i), PUB_RESET);
            rd_chk("irq en", OFF_IRQ_EN + 12'(4 * i), 32'h0);
        end
        rd_chk("status", OFF_SUPPLY_STAT, 32'h0);
        rd_chk("unmapped", 12'h7FC, 32'h0);
        // publish routing, enabled with a channel per event
        for (int i = 0; i < 3; i++) begin
            wr(OFF_PUB_ARRIVAL + 12'(4 * i), 32'h8000_0010 + 32'(i));
            rd_chk("pub rb", OFF_PUB_ARRIVAL + 12'(4 * i),
                   32'h8000_0010 + 32'(i));
        end
        // enable set, clear, zero writes and plain enable
        wr(OFF_IRQ_EN_SET, 32'h5);
        rd_chk("en set", OFF_IRQ_EN, 32'h5);
        wr(OFF_IRQ_EN_SET, 32'h0);
        rd_chk("en zero", OFF_IRQ_EN_CLR, 32'h5);
        wr(OFF_IRQ_EN_CLR, 32'h4);
        rd_chk("en clr", OFF_IRQ_EN_SET, 32'h1);
        wr(OFF_IRQ_EN, 32'h6);
        rd_chk("en plain", OFF_IRQ_EN, 32'h6);
        wr(OFF_IRQ_EN, 32'h1);
        // vbus alone: regulator stays off, arrival flag and irq
        @(posedge mclk_in);
        plug <= 1'b1;
        repeat (6) @(posedge mclk_in);
        #1;
        chk("reg off", 32'h0, {31'h0, reg_on_out});
        chk("irq on", 32'h1, {31'h0, irq_out});
        rd_chk("status vbus", OFF_SUPPLY_STAT, 32'h1);
        rd_chk("arrival", OFF_EV_ARRIVAL, 32'h1);
        wr(OFF_EV_ARRIVAL, 32'h0);
        chk("irq off", 32'h0, {31'h0, irq_out});
        // controller enabled: regulator on, ready after settling
        @(posedge mclk_in);
        usb_on <= 1'b1;
        wait_on(4, "reg on");
        wait_on(2, "ready fire");
        // n counts from the edge after the regulator came on
        chk("ready delay", 32'(SETTLE - 1), 32'(n));
        chk("ready chan", 32'h12, {24'h0, pub_out[2].chan});
        rd_chk("status ready", OFF_SUPPLY_STAT, 32'h3);
        rd_chk("ready flag", OFF_EV_READY, 32'h1);
        // cable pulled: loss event, regulator off
        @(posedge mclk_in);
        plug <= 1'b0;
        wait_on(1, "loss fire");
        chk("reg off 2", 32'h0, {31'h0, reg_on_out});
        rd_chk("loss flag", OFF_EV_LOSS, 32'h1);
        rd_chk("status gone", OFF_SUPPLY_STAT, 32'h0);
        // raise and mask the loss interrupt
        wr(OFF_IRQ_EN_SET, 32'h2);
        chk("irq loss", 32'h1, {31'h0, irq_out});
        wr(OFF_IRQ_EN_CLR, 32'h2);
        chk("irq masked", 32'h0, {31'h0, irq_out});
        // deep sleep, then vbus wakeup
        @(posedge mclk_in);
        usb_on <= 1'b0;
        sleep_req_in <= 1'b1;
        @(posedge mclk_in);
        sleep_req_in <= 1'b0;
        #1;
        chk("asleep", 32'h0, {31'h0, running_out});
        @(posedge mclk_in);
        plug <= 1'b1;
        wait_on(3, "wake reset");
        wait_on(5, "running");
        rd_chk("cause", OFF_RESET_CAUSE, 32'h1);
        wr(OFF_RESET_CAUSE, 32'h1);
        rd_chk("cause clr", OFF_RESET_CAUSE, 32'h0);
        conclude();
    end

    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge mclk_in);
        fails++;
        $display("BAD watchdog expected finish seen timeout");
        conclude();
    end
endmodule
`default_nettype wire
